// >>> src/dcg_pkg.sv
// Package of constants for the clock generator block
package dcg_pkg;
  // ==========================================================
  // Mode pin encodings, sampled at reset release
  localparam logic [2:0] MODE_PINS_DIV2_A = 3'h0;
  localparam logic [2:0] MODE_PINS_DIV2_B = 3'h7;
  localparam logic [2:0] MODE_PINS_DIV4 = 3'h5;
  // ==========================================================
  // Source selection
  typedef enum logic [1:0] {
    DCG_SRC_DIV2 = 2'h0,
    DCG_SRC_DIV4 = 2'h1,
    DCG_SRC_PLL = 2'h3
  } dcg_src_e;
  // ==========================================================
  // Lock state machine, one bit changes per step except LOCKED to BYPASS
  typedef enum logic [1:0] {
    DCG_ST_BYPASS = 2'h0,
    DCG_ST_RELOCK = 2'h1,
    DCG_ST_LOCKED = 2'h3
  } dcg_state_e;
  // ==========================================================
  // Clock mode register layout: [7:4] integer, [3:2] quarter, [1] pll enable,
  // [0] divide-by-four when bypassed
  localparam int MODE_W = 8;
  localparam int MUL_INT_LSB = 4;
  localparam int MUL_FRAC_LSB = 2;
  localparam int PLL_EN_BIT = 1;
  localparam int DIV4_BIT = 0;
  localparam logic [MODE_W-1:0] MODE_RESET = 8'h00;
  localparam logic [3:0] MUL_INT_MIN = 4'h1;
  // Quarter steps: multiplier in quarters is 4*int + frac, frac in 0..3
  localparam int MUL_Q_W = 6;
  localparam int ACC_W = 8;
  // ==========================================================
  // Output divide field
  localparam logic [1:0] DIVF_NONE = 2'h0;
  localparam logic [1:0] DIVF_BY2 = 2'h1;
  localparam logic [1:0] DIVF_BY4 = 2'h3;
  localparam logic [1:0] DIVF_RESET = DIVF_BY4;
  // ==========================================================
  // Lock time
  localparam int CLK_MHZ = 100;
  localparam int LOCK_TIME_US = 30;
  localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
  localparam int LOCK_CNT_W = 13;
endpackage

// >>> src/dcg_ref_div.sv
// Fixed divide-by-two or divide-by-four tick generator
`timescale 1ns/1ps
`default_nettype none
module dcg_ref_div (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Reference edge strobe, one cycle per reference period
  input wire logic ref_tick_i,
  // Control
  input wire logic div4_i,
  // Tick out
  output logic tick_o
);
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic last;
  // Counts reference edges, not system clocks: wrap at 1 for halving, at 3 for quartering
  assign last = div4_i ? (cnt_r == 2'h3) : cnt_r[0];
  assign cnt_nxt = !ref_tick_i ? cnt_r : (last ? 2'h0 : cnt_r + 2'h1);
  assign tick_o = ref_tick_i & last;
  // Purely synchronous, so a stalled reference just holds state
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule
`default_nettype wire

// >>> src/dcg_out_div.sv
// Machine clock output divider, divides machine ticks by 1, 2 or 4
`timescale 1ns/1ps
`default_nettype none
module dcg_out_div (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Machine tick and divide field
  input wire logic tick_i,
  input wire logic [1:0] divf_i,
  // Output clock level
  output logic clk_out_o
);
  logic [1:0] cnt_r;
  logic out_r;
  logic wrap;
  // Toggle point: every tick undivided, else at end of half period
  assign wrap = (divf_i == dcg_pkg::DIVF_NONE) ? 1'b1 :
                (divf_i == dcg_pkg::DIVF_BY2) ? 1'b1 : (cnt_r[0] == 1'b1);
  assign clk_out_o = out_r;
  // Undivided tracks tick level; divided toggles on ticks
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 2'h0;
      out_r <= 1'b0;
    end else if (divf_i == dcg_pkg::DIVF_NONE) begin
      out_r <= tick_i;
      cnt_r <= 2'h0;
    end else if (tick_i) begin
      cnt_r <= wrap ? 2'h0 : cnt_r + 2'h1;
      if (wrap) begin
        out_r <= ~out_r;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/dcg_top.sv
// Clock generator: mode strap capture, divide/multiply tick generation, lock timing
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
module dcg_top #(
  parameter int LOCK_CYCLES = dcg_pkg::LOCK_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Reference edge strobe (one cycle per reference period)
  input wire logic ref_tick_i,
  // Startup mode pins
  input wire logic mode_select_pin_one_i,
  input wire logic mode_select_pin_two_i,
  input wire logic mode_select_pin_three_i,
  // Clock mode register write port
  input wire logic clock_mode_register_we_i,
  input wire logic [dcg_pkg::MODE_W-1:0] clock_mode_register_wdata_i,
  // Output divide field write port
  input wire logic output_clock_divide_field_we_i,
  input wire logic [1:0] output_clock_divide_field_wdata_i,
  // Status and clocks
  output logic [dcg_pkg::MODE_W-1:0] clock_mode_register_o,
  output logic [1:0] output_clock_divide_field_o,
  output logic oscillator_enable_o,
  output logic pll_locked_o,
  output logic machine_tick_o,
  output logic machine_clock_output_o
);
  // ==========================================================
  // Strap capture
  logic strap_done_r;
  logic osc_en_r;
  logic [dcg_pkg::MODE_W-1:0] mode_r;
  logic [dcg_pkg::MODE_W-1:0] mode_nxt;
  logic [1:0] divf_r;
  logic [2:0] pins;
  logic pins_div4;
  logic pins_crystal;

  assign pins = {mode_select_pin_one_i, mode_select_pin_two_i, mode_select_pin_three_i};
  assign pins_div4 = (pins == dcg_pkg::MODE_PINS_DIV4);
  // Only the divide-by-two straps run from the oscillator here; others inject a reference
  assign pins_crystal = (pins == dcg_pkg::MODE_PINS_DIV2_A) ||
                        (pins == dcg_pkg::MODE_PINS_DIV2_B);

  // Startup mode: straps put into bypass, PLL off
  assign mode_nxt = clock_mode_register_we_i ? clock_mode_register_wdata_i :
                    !strap_done_r ? {{(dcg_pkg::MODE_W-1){1'b0}}, pins_div4} : mode_r;

  // Straps latched at first clock after reset release, never under reset
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done_r <= 1'b0;
      osc_en_r <= 1'b0;
      mode_r <= dcg_pkg::MODE_RESET;
    end else begin
      strap_done_r <= 1'b1;
      if (!strap_done_r) begin
        osc_en_r <= pins_crystal;
      end
      mode_r <= mode_nxt;
    end
  end

  // Output divide field
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      divf_r <= dcg_pkg::DIVF_RESET;
    end else if (output_clock_divide_field_we_i) begin
      divf_r <= output_clock_divide_field_wdata_i;
    end
  end

  // ==========================================================
  // Mode decode
  logic pll_en;
  logic [3:0] mul_int;
  logic [1:0] mul_frac;
  logic [dcg_pkg::MUL_Q_W-1:0] mul_q;

  assign pll_en = mode_r[dcg_pkg::PLL_EN_BIT];
  assign mul_int = mode_r[dcg_pkg::MUL_INT_LSB +: 4];
  assign mul_frac = mode_r[dcg_pkg::MUL_FRAC_LSB +: 2];
  // Integer 0 is clamped to 1 so the loop always produces ticks
  assign mul_q = {((mul_int < dcg_pkg::MUL_INT_MIN) ? dcg_pkg::MUL_INT_MIN : mul_int),
                  mul_frac};

  // ==========================================================
  // Lock state machine
  dcg_pkg::dcg_state_e state_r;
  dcg_pkg::dcg_state_e state_nxt;
  logic [dcg_pkg::LOCK_CNT_W-1:0] lock_cnt_r;
  logic [dcg_pkg::LOCK_CNT_W-1:0] lock_cnt_nxt;
  logic lock_done;

  assign lock_done = (lock_cnt_r >= dcg_pkg::LOCK_CNT_W'(LOCK_CYCLES - 1));

  // A factor change while locked restarts the lock wait
  always_comb begin
    state_nxt = state_r;
    lock_cnt_nxt = lock_cnt_r;
    case (state_r)
      dcg_pkg::DCG_ST_BYPASS: begin
        lock_cnt_nxt = '0;
        if (pll_en) begin
          state_nxt = dcg_pkg::DCG_ST_RELOCK;
        end
      end
      dcg_pkg::DCG_ST_RELOCK: begin
        lock_cnt_nxt = lock_cnt_r + 1'b1;
        if (!pll_en) begin
          state_nxt = dcg_pkg::DCG_ST_BYPASS;
        end else if (clock_mode_register_we_i) begin
          lock_cnt_nxt = '0;
        end else if (lock_done) begin
          state_nxt = dcg_pkg::DCG_ST_LOCKED;
        end
      end
      dcg_pkg::DCG_ST_LOCKED: begin
        lock_cnt_nxt = '0;
        if (!pll_en) begin
          state_nxt = dcg_pkg::DCG_ST_BYPASS;
        end else if (clock_mode_register_we_i) begin
          state_nxt = dcg_pkg::DCG_ST_RELOCK;
        end
      end
      default: begin
        state_nxt = dcg_pkg::DCG_ST_BYPASS;
        lock_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= dcg_pkg::DCG_ST_BYPASS;
      lock_cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      lock_cnt_r <= lock_cnt_nxt;
    end
  end

  // ==========================================================
  // Multiply: fractional-N accumulator adds quarters per reference tick,
  // emits one machine tick per 4 quarters, at most one per clock
  logic [dcg_pkg::ACC_W-1:0] acc_r;
  logic [dcg_pkg::ACC_W-1:0] acc_add;
  logic pll_tick;

  assign acc_add = acc_r + (ref_tick_i ? dcg_pkg::ACC_W'(mul_q) : '0);
  assign pll_tick = (acc_add >= dcg_pkg::ACC_W'(4));

  // Accumulator grows only with reference ticks; a stopped reference lets it drain by 4 per clock to below 4, then freezes it
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_r <= '0;
    end else if (state_r == dcg_pkg::DCG_ST_BYPASS) begin
      acc_r <= '0;
    end else begin
      acc_r <= pll_tick ? acc_add - dcg_pkg::ACC_W'(4) : acc_add;
    end
  end

  // ==========================================================
  // Divide: count reference ticks
  logic div_tick;
  logic ref_div_tick;
  logic div4_sel;

  assign div4_sel = mode_r[dcg_pkg::DIV4_BIT];

  dcg_ref_div u_ref_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ref_tick_i(ref_tick_i),
    .div4_i(div4_sel),
    .tick_o(ref_div_tick)
  );
  // Divider counter steps only on reference edges, so its tick is already qualified
  assign div_tick = ref_div_tick;

  // ==========================================================
  // Machine tick select, held off while the loop relocks
  logic mtick;
  assign mtick = pll_en ? (pll_tick && (state_r == dcg_pkg::DCG_ST_LOCKED)) : div_tick;

  logic mtick_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mtick_r <= 1'b0;
    end else begin
      mtick_r <= mtick;
    end
  end

  dcg_out_div u_out_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .tick_i(mtick_r),
    .divf_i(divf_r),
    .clk_out_o(machine_clock_output_o)
  );

  // ==========================================================
  // Status outputs
  assign clock_mode_register_o = mode_r;
  assign output_clock_divide_field_o = divf_r;
  assign oscillator_enable_o = osc_en_r;
  assign pll_locked_o = (state_r == dcg_pkg::DCG_ST_LOCKED);
  assign machine_tick_o = mtick_r;
endmodule
`default_nettype wire

// >>> dv/dcg_ref_src.sv
// Reference source model: one strobe per reference period
`timescale 1ns/1ps
`default_nettype none
module dcg_ref_src (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Pacing
  input wire logic run_i,
  input wire logic [7:0] period_i,
  // Reference strobe
  output logic ref_tick_o
);
  // ====
  // Strobe generator, silent while stopped like a halted crystal
  logic [7:0] cnt_r;
  logic wrap;
  assign wrap = run_i && (cnt_r >= period_i - 8'h01);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_r <= 8'h00;
      ref_tick_o <= 1'b0;
    end else begin
      cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01;
      ref_tick_o <= wrap;
    end
  end
endmodule
`default_nettype wire

// >>> dv/dcg_checker.sv
// Port assertions for the clock generator
`timescale 1ns/1ps
`default_nettype none
module dcg_checker #(
  parameter int LOCK_CYCLES = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Inputs
  input wire logic ref_tick_i,
  input wire logic mode_select_pin_one_i,
  input wire logic mode_select_pin_two_i,
  input wire logic mode_select_pin_three_i,
  input wire logic clock_mode_register_we_i,
  input wire logic [dcg_pkg::MODE_W-1:0] clock_mode_register_wdata_i,
  input wire logic output_clock_divide_field_we_i,
  input wire logic [1:0] output_clock_divide_field_wdata_i,
  // Outputs
  input wire logic [dcg_pkg::MODE_W-1:0] clock_mode_register_o,
  input wire logic [1:0] output_clock_divide_field_o,
  input wire logic oscillator_enable_o,
  input wire logic pll_locked_o,
  input wire logic machine_tick_o,
  input wire logic machine_clock_output_o
);
  // ====
  // Cycles since a loop-enabling write; saturates so it never wraps
  logic [15:0] wait_r;
  logic [2:0] pins;
  logic pll_wr;
  logic pll_on;
  assign pins = {mode_select_pin_one_i, mode_select_pin_two_i, mode_select_pin_three_i};
  assign pll_wr = clock_mode_register_we_i && clock_mode_register_wdata_i[dcg_pkg::PLL_EN_BIT];
  assign pll_on = clock_mode_register_o[dcg_pkg::PLL_EN_BIT];
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_r <= 16'h0000;
    end else if (pll_wr) begin
      wait_r <= 16'h0001;
    end else if (wait_r != 16'hFFFF) begin
      wait_r <= wait_r + 16'h0001;
    end
  end
  // Properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_release;
    !$past(rstn_i) && !clock_mode_register_we_i;
  endsequence
  sequence s_quiet;
    (!pll_on && !ref_tick_i)[*3];
  endsequence
  AST_STRAP_MODE: assert property (s_release |=>
    clock_mode_register_o == {7'h00, pins == dcg_pkg::MODE_PINS_DIV4}) else $error("strap mode");
  AST_STRAP_OSC: assert property (s_release |=> oscillator_enable_o ==
    (pins == dcg_pkg::MODE_PINS_DIV2_A || pins == dcg_pkg::MODE_PINS_DIV2_B)) else $error("osc");
  AST_DIVF_RESET: assert property (s_release |->
    output_clock_divide_field_o == dcg_pkg::DIVF_RESET) else $error("divf reset");
  AST_MODE_WRITE: assert property (clock_mode_register_we_i |=>
    clock_mode_register_o == $past(clock_mode_register_wdata_i)) else $error("mode write");
  AST_DIVF_WRITE: assert property (output_clock_divide_field_we_i |=>
    output_clock_divide_field_o == $past(output_clock_divide_field_wdata_i)) else $error("divf");
  AST_RELOCK: assert property (pll_wr |-> ##2 !pll_locked_o) else $error("relock");
  AST_LOCK_EARLY: assert property ($rose(pll_locked_o) |->
    wait_r >= LOCK_CYCLES + 1 && wait_r <= LOCK_CYCLES + 2) else $error("lock time");
  AST_LOCK_LATE: assert property (pll_on && wait_r == LOCK_CYCLES + 5 |->
    pll_locked_o) else $error("lock late");
  AST_UNLOCK: assert property (clock_mode_register_we_i && !pll_wr |=>
    !pll_locked_o) else $error("unlock");
  AST_STATIC: assert property (s_quiet |-> !machine_tick_o) else $error("tick");
  AST_UNDIV: assert property (output_clock_divide_field_o == 2'h0 &&
    $past(output_clock_divide_field_o) == 2'h0 |-> machine_clock_output_o == $past(machine_tick_o))
    else $error("undivided");
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the clock generator
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int LOCK = 20;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic run = 1'b1;
  logic [7:0] period = 8'h02;
  logic [2:0] pins = 3'h0;
  logic mode_we = 1'b0;
  logic [7:0] mode_wd = 8'h00;
  logic divf_we = 1'b0;
  logic [1:0] divf_wd = 2'h0;
  logic ref_tick, osc_en, locked, tick, clk_out;
  logic [7:0] mode_q;
  logic [1:0] divf_q;
  logic [2:0] strap [4] = '{3'h0, 3'h5, 3'h7, 3'h2};
  logic [5:0] mul [4] = '{6'h04, 6'h0A, 6'h1D, 6'h3F};
  int error_cnt = 0;
  int total_checks = 0;
  // ====
  // Reference source and device
  dcg_ref_src dcg_ref_src_inst (.clk_i(clk_i), .rstn_i(rstn_i), .run_i(run),
    .period_i(period), .ref_tick_o(ref_tick));
  dcg_top #(.LOCK_CYCLES(LOCK)) dcg_top_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .ref_tick_i(ref_tick), .mode_select_pin_one_i(pins[2]), .mode_select_pin_two_i(pins[1]),
    .mode_select_pin_three_i(pins[0]), .clock_mode_register_we_i(mode_we),
    .clock_mode_register_wdata_i(mode_wd), .output_clock_divide_field_we_i(divf_we),
    .output_clock_divide_field_wdata_i(divf_wd), .clock_mode_register_o(mode_q),
    .output_clock_divide_field_o(divf_q), .oscillator_enable_o(osc_en),
    .pll_locked_o(locked), .machine_tick_o(tick), .machine_clock_output_o(clk_out));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // Zero when inside the tolerance, else the distance off
  function automatic int near(input int v, input int e, input int tol);
    return (v >= e - tol && v <= e + tol) ? 0 : v - e;
  endfunction
  task automatic wr_mode(input logic [7:0] d);
    mode_we <= 1'b1;
    mode_wd <= d;
    @(posedge clk_i);
    mode_we <= 1'b0;
  endtask
  task automatic do_reset(input logic [2:0] p);
    rstn_i <= 1'b0;
    pins <= p;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
  endtask
  // Counts ticks and output toggles, sampled on the quiet edge
  task automatic count(input int n, output int t, output int g);
    logic last;
    t = 0;
    g = 0;
    @(negedge clk_i);
    last = clk_out;
    repeat (n) begin
      @(negedge clk_i);
      t += tick;
      g += (clk_out != last);
      last = clk_out;
    end
    @(posedge clk_i);
  endtask
  initial begin
    int t, g, w;
    for (int i = 0; i < 4; i++) begin
      do_reset(strap[i]);
      chk("mode", mode_q, {7'h00, strap[i] == 3'h5});
      chk("osc", osc_en, strap[i] == 3'h0 || strap[i] == 3'h7);
      chk("divf", divf_q, 2'h3);
      count(80, t, g);
      chk("ticks", near(t, strap[i] == 3'h5 ? 10 : 20, 1), 0);
      chk("out4", near(g, t / 2, 1), 0);
    end
    for (int i = 0; i < 2; i++) begin
      divf_we <= 1'b1;
      divf_wd <= 2'(i);
      @(posedge clk_i);
      divf_we <= 1'b0;
      count(80, t, g);
      chk("outclk", near(g, i == 0 ? 2 * t : t, 2), 0);
    end
    // Stopped reference keeps all state
    run <= 1'b0;
    count(4, t, g);
    count(50, t, g);
    chk("stopped", t, 0);
    chk("kept", divf_q, 2'h1);
    run <= 1'b1;
    count(80, t, g);
    chk("resumed", near(t, 20, 1), 0);
    // Multiply mode at four quarter-step factors; each write relocks
    period <= 8'h10;
    for (int i = 0; i < 4; i++) begin
      wr_mode({mul[i], 2'h2});
      repeat (2) @(posedge clk_i);
      w = 2;
      while (locked !== 1'b1 && w < 100) begin
        @(negedge clk_i);
        w++;
      end
      @(posedge clk_i);
      if (w >= 100) begin
        error_cnt++;
        test_done();
      end
      chk("lock", near(w, LOCK + 3, 2), 0);
      chk("mult", mode_q, {mul[i], 2'h2});
      count(320, t, g);
      chk("mticks", near(t, 5 * mul[i], 3), 0);
    end
    wr_mode(8'h01);
    period <= 8'h02;
    repeat (2) @(posedge clk_i);
    chk("unlock", locked, 1'b0);
    count(80, t, g);
    chk("div4", near(t, 10, 2), 0);
    test_done();
  end
endmodule
bind dcg_top dcg_checker #(.LOCK_CYCLES(LOCK_CYCLES)) dcg_checker_inst (.*);
`default_nettype wire
